// ==== rtl/arith_unit.v ====
// Purpose: byte arithmetic with carry, half carry and overflow results
// Assumes: purely combinational, driven by the core register block
// Notes: second operand of mul and div is the auxiliary register
`timescale 1ns/10ps
`include "cpu_core_regs_consts.vh"

module arith_unit (
  input wire [2:0] op,
  input wire [7:0] a,
  input wire [7:0] b,
  input wire cin,
  output reg [7:0] res_a,
  output reg [7:0] res_b,
  output reg carry_res,
  output reg half_res,
  output reg excess_res,
  output reg upd_a,
  output reg upd_b,
  output reg upd_flags
);

reg [8:0] wide;
reg [4:0] nib;
reg [15:0] prod;
reg c_eff;

////////////////////////////////////////////////////////////////////////////////
// one case per operation, add and addc sharing one; idle keeps every update strobe low
always @*
begin
  wide = 9'h000;
  nib = 5'h00;
  prod = 16'h0000;
  c_eff = (op == `ALU_ADDC) ? cin : 1'b0;
  res_a = a;
  res_b = b;
  carry_res = 1'b0;
  half_res = 1'b0;
  excess_res = 1'b0;
  upd_a = 1'b0;
  upd_b = 1'b0;
  upd_flags = 1'b0;
  case (op)
    `ALU_ADD, `ALU_ADDC:
    begin
      wide = {1'b0, a} + {1'b0, b} + {8'h00, c_eff};
      nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c_eff};
      res_a = wide[7:0];
      carry_res = wide[8];
      half_res = nib[4];
      excess_res = (a[7] == b[7]) && (wide[7] != a[7]);
      upd_a = 1'b1;
      upd_flags = 1'b1;
    end
    `ALU_SUBB:
    begin
      wide = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
      res_a = wide[7:0];
      carry_res = wide[8];
      half_res = nib[4];
      excess_res = (a[7] != b[7]) && (wide[7] != a[7]);
      upd_a = 1'b1;
      upd_flags = 1'b1;
    end
    `ALU_MUL:
    begin
      prod = {8'h00, a} * {8'h00, b};
      res_a = prod[7:0];
      res_b = prod[15:8];
      excess_res = (prod[15:8] != 8'h00);
      upd_a = 1'b1;
      upd_b = 1'b1;
      upd_flags = 1'b1;
    end
    `ALU_DIV:
    begin
      // a zero divisor leaves both operands as they were
      excess_res = (b == 8'h00);
      if (b != 8'h00)
      begin
        res_a = a / b;
        res_b = a % b;
        upd_a = 1'b1;
        upd_b = 1'b1;
      end
      upd_flags = 1'b1;
    end
    default:
    begin
      upd_flags = 1'b0;
    end
  endcase
end

endmodule // arith_unit

// ==== rtl/cpu_core_regs.v ====
// Purpose: status word, main operand, aux, stack top and dual data pointers
// Assumes: execution unit and register bus share CORE_CLK, no pin inputs
// Notes: register reads answer one cycle after SFR_RD
`timescale 1ns/10ps
`include "cpu_core_regs_consts.vh"

// Notes on behaviour
// - stack top increments before each push write
// - stack top resets to 07h, first push 08h
// - stack may sit anywhere, 256 deep
// - carry set on carry or borrow, else cleared
// - half carry tracks low nibble carry or borrow
// - carry is the boolean bit operand
// - two bank bits pick register bank base
// - signed overflow of add, addc, subb
// - overflow when product exceeds 255
// - overflow on divide by zero
// - those ops otherwise clear overflow
// - parity is odd count of operand ones
// - two user flags, software only
// - aux register feeds and receives mul, div
// - pointer accessed as word or bytes
// - two pointers share address, chosen by bit0
// - choice 0 primary, 1 secondary, reset 0
// - increment of control toggles choice, pointers kept
// - bit3 spare software flag, others unused
module cpu_core_regs (
  input wire CORE_CLK,
  input wire RST,
  input wire [7:0] SFR_ADDR,
  input wire SFR_WR,
  input wire [7:0] SFR_WDATA,
  input wire SFR_RD,
  output reg [7:0] SFR_RDATA,
  output reg SFR_HIT,
  input wire [2:0] ALU_OP,
  input wire [2:0] BOOL_OP,
  input wire BOOL_IN,
  input wire OPND_WR,
  input wire [7:0] OPND_WDATA,
  input wire [1:0] STACK_OP,
  output reg [7:0] STACK_ADDR,
  output reg STACK_VALID,
  input wire PTR_LOAD,
  input wire PTR_INC,
  input wire [15:0] PTR_WDATA,
  input wire CHOICE_TOGGLE,
  output reg [7:0] MAIN_OUT,
  output reg [7:0] AUX_OUT,
  output reg [7:0] STATUS_OUT,
  output reg CARRY_OUT,
  output reg [4:0] BANK_BASE,
  output reg [15:0] PTR_OUT,
  output reg [7:0] STACK_TOP_OUT
);

////////////////////////////////////////////////////////////////////////////////
// state
reg [7:0] main_q;
reg [7:0] main_d;
reg [7:0] aux_q;
reg [7:0] aux_d;
reg [7:0] status_q;
reg [7:0] status_d;
reg [7:0] stack_q;
reg [7:0] stack_d;
reg choice_q;
reg choice_d;
reg spare_q;
reg spare_d;

// arithmetic results
wire [7:0] alu_a;
wire [7:0] alu_b;
wire alu_carry;
wire alu_half;
wire alu_excess;
wire alu_upd_a;
wire alu_upd_b;
wire alu_upd_flags;

// pointer strobes and values
wire [15:0] ptr0_q;
wire [15:0] ptr0_d;
wire [15:0] ptr1_q;
wire [15:0] ptr1_d;
wire wr_low;
wire wr_high;
reg bool_next;

////////////////////////////////////////////////////////////////////////////////
// address decode of bus writes
wire wr_main = SFR_WR && (SFR_ADDR == `ADDR_MAIN_OPERAND_REG);
wire wr_aux = SFR_WR && (SFR_ADDR == `ADDR_MUL_DIV_AUX_REG);
wire wr_status = SFR_WR && (SFR_ADDR == `ADDR_CPU_STATUS_WORD);
wire wr_stack = SFR_WR && (SFR_ADDR == `ADDR_STACK_TOP);
wire wr_select = SFR_WR && (SFR_ADDR == `ADDR_POINTER_SELECT_CTRL);
assign wr_low = SFR_WR && (SFR_ADDR == `ADDR_POINTER_LOW_BYTE);
assign wr_high = SFR_WR && (SFR_ADDR == `ADDR_POINTER_HIGH_BYTE);

////////////////////////////////////////////////////////////////////////////////
// arithmetic on the main operand and the aux register
arith_unit u_arith (
  .op(ALU_OP),
  .a(main_q),
  .b(aux_q),
  .cin(status_q[`BIT_CARRY]),
  .res_a(alu_a),
  .res_b(alu_b),
  .carry_res(alu_carry),
  .half_res(alu_half),
  .excess_res(alu_excess),
  .upd_a(alu_upd_a),
  .upd_b(alu_upd_b),
  .upd_flags(alu_upd_flags)
);

////////////////////////////////////////////////////////////////////////////////
// two pointers on one address; only the chosen one sees any access
pointer_reg u_ptr0 (
  .clk(CORE_CLK),
  .rst(RST),
  .load_word(PTR_LOAD && !choice_q),
  .inc_word(PTR_INC && !choice_q),
  .wr_low(wr_low && !choice_q),
  .wr_high(wr_high && !choice_q),
  .word_in(PTR_WDATA),
  .byte_in(SFR_WDATA),
  .value_q(ptr0_q),
  .value_d(ptr0_d)
);

pointer_reg u_ptr1 (
  .clk(CORE_CLK),
  .rst(RST),
  .load_word(PTR_LOAD && choice_q),
  .inc_word(PTR_INC && choice_q),
  .wr_low(wr_low && choice_q),
  .wr_high(wr_high && choice_q),
  .word_in(PTR_WDATA),
  .byte_in(SFR_WDATA),
  .value_q(ptr1_q),
  .value_d(ptr1_d)
);

////////////////////////////////////////////////////////////////////////////////
// main operand: arithmetic result beats the direct write port,
// which beats a bus write
always @*
begin
  main_d = main_q;
  if (alu_upd_a)
    main_d = alu_a;
  else if (OPND_WR)
    main_d = OPND_WDATA;
  else if (wr_main)
    main_d = SFR_WDATA;
end

// aux register is plain scratch unless mul or div claims it
always @*
begin
  aux_d = aux_q;
  if (alu_upd_b)
    aux_d = alu_b;
  else if (wr_aux)
    aux_d = SFR_WDATA;
end

////////////////////////////////////////////////////////////////////////////////
// boolean result with the carry as working operand
always @*
begin
  bool_next = status_q[`BIT_CARRY];
  case (BOOL_OP)
    `BOOL_CLR: bool_next = 1'b0;
    `BOOL_SET: bool_next = 1'b1;
    `BOOL_CPL: bool_next = !status_q[`BIT_CARRY];
    `BOOL_AND: bool_next = status_q[`BIT_CARRY] & BOOL_IN;
    `BOOL_OR: bool_next = status_q[`BIT_CARRY] | BOOL_IN;
    `BOOL_MOV: bool_next = BOOL_IN;
    `BOOL_ANDN: bool_next = status_q[`BIT_CARRY] & !BOOL_IN;
    default: bool_next = status_q[`BIT_CARRY];
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// status word: bus write first, then hardware flag updates on top,
// so an arithmetic result is never lost to a same-cycle write
always @*
begin
  status_d = status_q;
  if (wr_status)
    status_d = SFR_WDATA;
  if (alu_upd_flags)
  begin
    status_d[`BIT_CARRY] = alu_carry;
    status_d[`BIT_HALF_CARRY] = alu_half;
    status_d[`BIT_EXCESS] = alu_excess;
  end
  else if (BOOL_OP != `BOOL_NONE)
    status_d[`BIT_CARRY] = bool_next;
  // parity follows the next operand value, never the bus write
  status_d[`BIT_PARITY] = ^main_d;
end

////////////////////////////////////////////////////////////////////////////////
// stack top: pre-increment on push, post-decrement on pop;
// the 8-bit width wraps 0ffh to 00h with no error
always @*
begin
  stack_d = stack_q;
  case (STACK_OP)
    `STK_PUSH: stack_d = stack_q + 8'h01;
    `STK_POP: stack_d = stack_q - 8'h01;
    default:
    begin
      if (wr_stack)
        stack_d = SFR_WDATA;
    end
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// pointer choice: the toggle strobe stands for an increment of the
// control register, and only bit 0 of that value changes
always @*
begin
  choice_d = choice_q;
  spare_d = spare_q;
  if (CHOICE_TOGGLE)
    choice_d = !choice_q;
  else if (wr_select)
  begin
    choice_d = SFR_WDATA[`BIT_POINTER_CHOICE];
    spare_d = SFR_WDATA[`BIT_SPARE_SW_FLAG];
  end
end

////////////////////////////////////////////////////////////////////////////////
// state registers
always @(posedge CORE_CLK)
begin
  if (RST)
  begin
    main_q <= `RESET_MAIN_OPERAND;
    aux_q <= `RESET_MUL_DIV_AUX;
    status_q <= `RESET_STATUS_WORD;
    stack_q <= `RESET_STACK_TOP;
    choice_q <= `RESET_POINTER_CHOICE;
    spare_q <= 1'b0;
  end
  else
  begin
    main_q <= main_d;
    aux_q <= aux_d;
    status_q <= status_d;
    stack_q <= stack_d;
    choice_q <= choice_d;
    spare_q <= spare_d;
  end
end

////////////////////////////////////////////////////////////////////////////////
// visible copies are taken from next values so they match the state
// registers cycle for cycle while still coming straight off a flop
always @(posedge CORE_CLK)
begin
  if (RST)
  begin
    MAIN_OUT <= `RESET_MAIN_OPERAND;
    AUX_OUT <= `RESET_MUL_DIV_AUX;
    STATUS_OUT <= `RESET_STATUS_WORD;
    CARRY_OUT <= 1'b0;
    BANK_BASE <= 5'h00;
    PTR_OUT <= `RESET_POINTER;
    STACK_TOP_OUT <= `RESET_STACK_TOP;
  end
  else
  begin
    MAIN_OUT <= main_d;
    AUX_OUT <= aux_d;
    STATUS_OUT <= status_d;
    CARRY_OUT <= status_d[`BIT_CARRY];
    // bank base is bank number times eight: 00h, 08h, 10h, 18h
    BANK_BASE <= {status_d[`BIT_BANK_HI], status_d[`BIT_BANK_LO], 3'h0};
    PTR_OUT <= choice_d ? ptr1_d : ptr0_d;
    STACK_TOP_OUT <= stack_d;
  end
end

////////////////////////////////////////////////////////////////////////////////
// stack memory address: a push uses the incremented top, a pop the
// current top before it drops
always @(posedge CORE_CLK)
begin
  if (RST)
  begin
    STACK_ADDR <= `RESET_STACK_TOP;
    STACK_VALID <= 1'b0;
  end
  else
  begin
    STACK_VALID <= (STACK_OP == `STK_PUSH) || (STACK_OP == `STK_POP);
    if (STACK_OP == `STK_PUSH)
      STACK_ADDR <= stack_q + 8'h01;
    else if (STACK_OP == `STK_POP)
      STACK_ADDR <= stack_q;
  end
end

////////////////////////////////////////////////////////////////////////////////
// bus reads, answered one cycle later; unused control bits read zero
// and an unmapped address answers zero with the hit flag low
always @(posedge CORE_CLK)
begin
  if (RST)
  begin
    SFR_RDATA <= 8'h00;
    SFR_HIT <= 1'b0;
  end
  else if (SFR_RD)
  begin
    SFR_HIT <= 1'b1;
    case (SFR_ADDR)
      `ADDR_MAIN_OPERAND_REG: SFR_RDATA <= main_q;
      `ADDR_MUL_DIV_AUX_REG: SFR_RDATA <= aux_q;
      `ADDR_CPU_STATUS_WORD: SFR_RDATA <= status_q;
      `ADDR_STACK_TOP: SFR_RDATA <= stack_q;
      `ADDR_POINTER_LOW_BYTE: SFR_RDATA <= choice_q ? ptr1_q[7:0] : ptr0_q[7:0];
      `ADDR_POINTER_HIGH_BYTE: SFR_RDATA <= choice_q ? ptr1_q[15:8] : ptr0_q[15:8];
      `ADDR_POINTER_SELECT_CTRL: SFR_RDATA <= {4'h0, spare_q, 2'h0, choice_q};
      default:
      begin
        SFR_RDATA <= 8'h00;
        SFR_HIT <= 1'b0;
      end
    endcase
  end
  else
  begin
    SFR_RDATA <= 8'h00;
    SFR_HIT <= 1'b0;
  end
end

endmodule // cpu_core_regs

// ==== rtl/cpu_core_regs_consts.vh ====
// Purpose: constants shared by the cpu status, stack and pointer block
// Assumes: special function register addresses are 8-bit byte addresses
// Notes: definitions only, no logic
`ifndef CPU_CORE_REGS_CONSTS_VH
`define CPU_CORE_REGS_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// special function register addresses
`define ADDR_POINTER_SELECT_CTRL 8'ha2
`define ADDR_CPU_STATUS_WORD 8'hd0
`define ADDR_MAIN_OPERAND_REG 8'he0
`define ADDR_MUL_DIV_AUX_REG 8'hf0
`define ADDR_STACK_TOP 8'h81
`define ADDR_POINTER_LOW_BYTE 8'h82
`define ADDR_POINTER_HIGH_BYTE 8'h83

////////////////////////////////////////////////////////////////////////////////
// reset values
`define RESET_STACK_TOP 8'h07
`define RESET_STATUS_WORD 8'h00
`define RESET_MAIN_OPERAND 8'h00
`define RESET_MUL_DIV_AUX 8'h00
`define RESET_POINTER 16'h0000
`define RESET_POINTER_CHOICE 1'b0

////////////////////////////////////////////////////////////////////////////////
// status word field positions
`define BIT_CARRY 7
`define BIT_HALF_CARRY 6
`define BIT_USER_ZERO 5
`define BIT_BANK_HI 4
`define BIT_BANK_LO 3
`define BIT_EXCESS 2
`define BIT_USER_ONE 1
`define BIT_PARITY 0

// pointer select control field positions
`define BIT_POINTER_CHOICE 0
`define BIT_SPARE_SW_FLAG 3

////////////////////////////////////////////////////////////////////////////////
// arithmetic operation codes
`define ALU_NONE 3'h0
`define ALU_ADD 3'h1
`define ALU_ADDC 3'h2
`define ALU_SUBB 3'h3
`define ALU_MUL 3'h4
`define ALU_DIV 3'h5

// boolean carry operation codes
`define BOOL_NONE 3'h0
`define BOOL_CLR 3'h1
`define BOOL_SET 3'h2
`define BOOL_CPL 3'h3
`define BOOL_AND 3'h4
`define BOOL_OR 3'h5
`define BOOL_MOV 3'h6
`define BOOL_ANDN 3'h7

// stack operation codes
`define STK_NONE 2'h0
`define STK_PUSH 2'h1
`define STK_POP 2'h2

`endif

// ==== rtl/pointer_reg.v ====
// Purpose: one 16-bit data pointer with word and byte access
// Assumes: all strobes come from logic on the same clock
// Notes: word load beats increment, increment beats byte writes
`timescale 1ns/10ps
`include "cpu_core_regs_consts.vh"

module pointer_reg (
  input wire clk,
  input wire rst,
  input wire load_word,
  input wire inc_word,
  input wire wr_low,
  input wire wr_high,
  input wire [15:0] word_in,
  input wire [7:0] byte_in,
  output reg [15:0] value_q,
  output reg [15:0] value_d
);

////////////////////////////////////////////////////////////////////////////////
// next value; both byte halves may be written in one cycle
always @*
begin
  value_d = value_q;
  if (load_word)
    value_d = word_in;
  else if (inc_word)
    value_d = value_q + 16'h0001;
  else
  begin
    if (wr_low)
      value_d[7:0] = byte_in;
    if (wr_high)
      value_d[15:8] = byte_in;
  end
end

// state register
always @(posedge clk)
begin
  if (rst)
    value_q <= `RESET_POINTER;
  else
    value_q <= value_d;
end

endmodule // pointer_reg

// ==== testbench/cpu_core_regs_asserts.sv ====
// Purpose: port-level checks on the core status, stack and pointer block
// Assumes: one clock, synchronous active-high reset
// Notes: bound to the design top at the foot of this file
`timescale 1ns/10ps
module cpu_core_regs_chk (
  input logic CORE_CLK,
  input logic RST,
  input logic [7:0] SFR_ADDR,
  input logic SFR_WR,
  input logic SFR_RD,
  input logic [7:0] SFR_RDATA,
  input logic SFR_HIT,
  input logic [2:0] ALU_OP,
  input logic [1:0] STACK_OP,
  input logic [7:0] STACK_ADDR,
  input logic STACK_VALID,
  input logic PTR_LOAD,
  input logic PTR_INC,
  input logic CHOICE_TOGGLE,
  input logic [7:0] MAIN_OUT,
  input logic [7:0] AUX_OUT,
  input logic [7:0] STATUS_OUT,
  input logic CARRY_OUT,
  input logic [4:0] BANK_BASE,
  input logic [15:0] PTR_OUT,
  input logic [7:0] STACK_TOP_OUT
);
  default clocking dc @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////
  // multi-step behaviours
  sequence s_push; STACK_OP == 2'h1; endsequence
  sequence s_pop; STACK_OP == 2'h2; endsequence
  // byte writes excluded: they could retarget the chosen pointer
  sequence s_tog2; (CHOICE_TOGGLE && !PTR_LOAD && !PTR_INC && !SFR_WR) [*2]; endsequence
  sequence s_rd_stat; SFR_RD && SFR_ADDR == 8'hd0; endsequence
  ////////////////////////////////////////////////////////////
  // properties
  property p_rst; $fell(RST) |-> STACK_TOP_OUT == 8'h07 && PTR_OUT == 16'h0000; endproperty
  property p_push;
    s_push |=> STACK_TOP_OUT == 8'($past(STACK_TOP_OUT) + 8'h01) && STACK_ADDR == STACK_TOP_OUT
      && STACK_VALID;
  endproperty
  property p_pop;
    s_pop |=> STACK_TOP_OUT == 8'($past(STACK_TOP_OUT) - 8'h01)
      && STACK_ADDR == $past(STACK_TOP_OUT);
  endproperty
  property p_par; STATUS_OUT[0] == ^MAIN_OUT; endproperty
  property p_bank; BANK_BASE == {STATUS_OUT[4:3], 3'b000}; endproperty
  property p_carry; CARRY_OUT == STATUS_OUT[7]; endproperty
  // product above 255 exactly when the high byte is nonzero
  property p_mul; ALU_OP == 3'h4 |=> STATUS_OUT[2] == (AUX_OUT != 8'h00); endproperty
  property p_divz;
    ALU_OP == 3'h5 && AUX_OUT == 8'h00 |=> STATUS_OUT[2] && !STATUS_OUT[7]
      && MAIN_OUT == $past(MAIN_OUT);
  endproperty
  property p_tog; s_tog2 |=> PTR_OUT == $past(PTR_OUT, 2); endproperty
  property p_rd; s_rd_stat |=> SFR_HIT && SFR_RDATA == $past(STATUS_OUT); endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  a_push: assert property (p_push) else $error("push step wrong");
  a_pop: assert property (p_pop) else $error("pop step wrong");
  a_par: assert property (p_par) else $error("parity wrong");
  a_bank: assert property (p_bank) else $error("bank base wrong");
  a_carry: assert property (p_carry) else $error("carry bit mismatch");
  a_mul: assert property (p_mul) else $error("mul overflow wrong");
  a_divz: assert property (p_divz) else $error("divide by zero wrong");
  a_tog: assert property (p_tog) else $error("double toggle moved pointer");
  a_rd: assert property (p_rd) else $error("status read wrong");
endmodule // cpu_core_regs_chk

bind cpu_core_regs cpu_core_regs_chk u_chk (.CORE_CLK(CORE_CLK), .RST(RST),
  .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
  .SFR_HIT(SFR_HIT), .ALU_OP(ALU_OP), .STACK_OP(STACK_OP), .STACK_ADDR(STACK_ADDR),
  .STACK_VALID(STACK_VALID), .PTR_LOAD(PTR_LOAD), .PTR_INC(PTR_INC),
  .CHOICE_TOGGLE(CHOICE_TOGGLE), .MAIN_OUT(MAIN_OUT), .AUX_OUT(AUX_OUT),
  .STATUS_OUT(STATUS_OUT), .CARRY_OUT(CARRY_OUT), .BANK_BASE(BANK_BASE),
  .PTR_OUT(PTR_OUT), .STACK_TOP_OUT(STACK_TOP_OUT));

// ==== testbench/test_cpu_core_regs.sv ====
// Purpose: random and corner stimulus for the core register block
// Assumes: inputs change at the falling edge, outputs read one edge later
// Notes: an idle edge between operations keeps each input single-driven per step
`timescale 1ns/10ps
module test_cpu_core_regs;
  reg CORE_CLK, RST, SFR_WR, SFR_RD, BOOL_IN, OPND_WR, PTR_LOAD, PTR_INC, CHOICE_TOGGLE, c;
  reg [7:0] SFR_ADDR, SFR_WDATA, OPND_WDATA, a, b, e8;
  reg [2:0] ALU_OP, BOOL_OP, op;
  reg [1:0] STACK_OP;
  reg [15:0] PTR_WDATA, e16;
  reg [18:0] ex;
  reg [31:0] r;
  wire [7:0] SFR_RDATA, STACK_ADDR, MAIN_OUT, AUX_OUT, STATUS_OUT, STACK_TOP_OUT;
  wire [4:0] BANK_BASE;
  wire [15:0] PTR_OUT;
  wire SFR_HIT, STACK_VALID, CARRY_OUT;
  integer n_errors, checks, i;

  cpu_core_regs DUT (.CORE_CLK(CORE_CLK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
    .SFR_WDATA(SFR_WDATA), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT),
    .ALU_OP(ALU_OP), .BOOL_OP(BOOL_OP), .BOOL_IN(BOOL_IN), .OPND_WR(OPND_WR),
    .OPND_WDATA(OPND_WDATA), .STACK_OP(STACK_OP), .STACK_ADDR(STACK_ADDR),
    .STACK_VALID(STACK_VALID), .PTR_LOAD(PTR_LOAD), .PTR_INC(PTR_INC), .PTR_WDATA(PTR_WDATA),
    .CHOICE_TOGGLE(CHOICE_TOGGLE), .MAIN_OUT(MAIN_OUT), .AUX_OUT(AUX_OUT),
    .STATUS_OUT(STATUS_OUT), .CARRY_OUT(CARRY_OUT), .BANK_BASE(BANK_BASE),
    .PTR_OUT(PTR_OUT), .STACK_TOP_OUT(STACK_TOP_OUT));

  ////////////////////////////////////////////////////////////
  // expectation helpers
  function [31:0] xs(input [31:0] v);
    begin
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      xs = v ^ (v << 5);
    end
  endfunction

  // packs {main, aux, carry, half carry, overflow}
  function [18:0] alu(input [2:0] k, input [7:0] x, input [7:0] y, input ci);
    reg [8:0] s;
    reg [15:0] p;
    begin
      s = {1'b0, x} - y - ci;
      alu = {s[7:0], y, s[8], {1'b0, x[3:0]} < y[3:0] + ci, x[7] != y[7] && s[7] != x[7]};
      if (k == 3'h1 || k == 3'h2)
      begin
        ci = ci & (k == 3'h2);
        s = x + y + ci;
        alu = {s[7:0], y, s[8], ({1'b0, x[3:0]} + y[3:0] + ci) > 5'h0f,
          x[7] == y[7] && s[7] != x[7]};
      end
      p = x * y;
      if (k == 3'h4)
        alu = {p[7:0], p[15:8], 2'b00, p[15:8] != 8'h00};
      if (k == 3'h5)
        alu = (y == 8'h00) ? {x, y, 3'b001} : {x / y, x % y, 3'b000};
    end
  endfunction

  function bexp(input [2:0] k, input ci, input bi);
    begin
      case (k)
        3'h1: bexp = 1'b0;
        3'h2: bexp = 1'b1;
        3'h3: bexp = ~ci;
        3'h4: bexp = ci & bi;
        3'h5: bexp = ci | bi;
        3'h6: bexp = bi;
        default: bexp = ci & ~bi;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////
  // drive and compare tasks
  task clr;
    begin
      SFR_WR = 1'b0;
      SFR_RD = 1'b0;
      ALU_OP = 3'h0;
      BOOL_OP = 3'h0;
      OPND_WR = 1'b0;
      STACK_OP = 2'h0;
      PTR_LOAD = 1'b0;
      PTR_INC = 1'b0;
      CHOICE_TOGGLE = 1'b0;
    end
  endtask

  // lets the action edge land, then releases the strobes
  task go;
    begin
      @(negedge CORE_CLK);
      clr;
    end
  endtask

  task cmp(input [15:0] g, input [15:0] e);
    begin
      checks = checks + 1;
      if (g !== e)
      begin
        n_errors = n_errors + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask

  task wr(input [7:0] ad, input [7:0] d);
    begin
      @(negedge CORE_CLK);
      SFR_ADDR = ad;
      SFR_WDATA = d;
      SFR_WR = 1'b1;
      go;
    end
  endtask

  // read data is valid right after the read edge
  task rd(input [7:0] ad);
    begin
      @(negedge CORE_CLK);
      SFR_ADDR = ad;
      SFR_RD = 1'b1;
      go;
    end
  endtask

  task close_out;
    begin
      $display("errors=%0d checks=%0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  ////////////////////////////////////////////////////////////
  // clock and hang guard
  initial
  begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end

  initial
  begin
    repeat (20000) @(posedge CORE_CLK);
    n_errors = n_errors + 1;
    close_out;
  end

  // main sequence
  initial
  begin
    r = 32'hdc51_e63a;
    n_errors = 0;
    checks = 0;
    RST = 1'b1;
    SFR_ADDR = 8'h00;
    SFR_WDATA = 8'h00;
    OPND_WDATA = 8'h00;
    PTR_WDATA = 16'h0000;
    BOOL_IN = 1'b0;
    clr;
    repeat (12) @(negedge CORE_CLK);
    RST = 1'b0;
    // reset values, last address unmapped
    for (i = 0; i < 8; i = i + 1)
    begin
      rd(8'(64'ha2d0_e0f0_8182_8390 >> (56 - 8 * i)));
      cmp(SFR_RDATA, 8'(64'h0000_0000_0700_0000 >> (56 - 8 * i)));
      cmp(SFR_HIT, i < 7);
    end
    // bank select and user flags, parity bit write ignored
    for (i = 0; i < 4; i = i + 1)
    begin
      e8 = {2'b00, i[0], i[1:0], 1'b0, ~i[0], 1'b1};
      wr(8'hd0, e8);
      cmp(BANK_BASE, {i[1:0], 3'b000});
      rd(8'hd0);
      cmp(SFR_RDATA, {e8[7:1], 1'b0});
    end
    wr(8'hd0, 8'h00);
    // stack: first push, pop, wrap both ways, random start
    @(negedge CORE_CLK) STACK_OP = 2'h1;
    go;
    cmp({STACK_VALID, STACK_ADDR, STACK_TOP_OUT}, 17'h1_0808);
    @(negedge CORE_CLK) STACK_OP = 2'h2;
    go;
    cmp({STACK_ADDR, STACK_TOP_OUT}, 16'h0807);
    wr(8'h81, 8'hff);
    @(negedge CORE_CLK) STACK_OP = 2'h1;
    go;
    cmp({STACK_ADDR, STACK_TOP_OUT}, 16'h0000);
    @(negedge CORE_CLK) STACK_OP = 2'h2;
    go;
    cmp(STACK_TOP_OUT, 8'hff);
    r = xs(r);
    wr(8'h81, r[7:0]);
    e8 = r[7:0] + 8'h01;
    @(negedge CORE_CLK) STACK_OP = 2'h1;
    go;
    cmp(STACK_ADDR, e8);
    // arithmetic: corners first, then random
    for (i = 0; i < 40; i = i + 1)
    begin
      r = xs(r);
      op = r[2:0] % 3'h5 + 3'h1;
      {c, b, a} = r[16:0];
      case (i)
        0: {op, a, b} = 19'h1_ff01;
        1: {op, b} = 11'h500;
        2: {op, a, b} = 19'h4_1010;
        3: {op, a, b} = 19'h3_0001;
        4: {op, a, b, c} = 20'h4_fe01;
        default: ;
      endcase
      @(negedge CORE_CLK);
      OPND_WR = 1'b1;
      OPND_WDATA = a;
      BOOL_OP = c ? 3'h2 : 3'h1;
      SFR_ADDR = 8'hf0;
      SFR_WDATA = b;
      SFR_WR = 1'b1;
      go;
      @(negedge CORE_CLK) ALU_OP = op;
      go;
      ex = alu(op, a, b, c);
      cmp(MAIN_OUT, ex[18:11]);
      cmp(AUX_OUT, ex[10:3]);
      cmp({STATUS_OUT[7:6], STATUS_OUT[2]}, ex[2:0]);
      cmp(STATUS_OUT[0], ^ex[18:11]);
    end
    // boolean carry operations, every code but BOOL_NONE
    for (i = 1; i < 8; i = i + 1)
    begin
      r = xs(r);
      @(negedge CORE_CLK) BOOL_OP = r[0] ? 3'h2 : 3'h1;
      go;
      @(negedge CORE_CLK);
      BOOL_OP = i[2:0];
      BOOL_IN = r[1];
      go;
      cmp(CARRY_OUT, bexp(i[2:0], r[0], r[1]));
    end
    // dual pointers
    @(negedge CORE_CLK);
    PTR_LOAD = 1'b1;
    PTR_WDATA = 16'h01ff;
    go;
    cmp(PTR_OUT, 16'h01ff);
    @(negedge CORE_CLK) CHOICE_TOGGLE = 1'b1;
    go;
    cmp(PTR_OUT, 16'h0000);
    r = xs(r);
    wr(8'h82, r[7:0]);
    wr(8'h83, r[15:8]);
    cmp(PTR_OUT, r[15:0]);
    @(negedge CORE_CLK) PTR_INC = 1'b1;
    go;
    e16 = r[15:0] + 16'h0001;
    cmp(PTR_OUT, e16);
    rd(8'ha2);
    cmp(SFR_RDATA, 8'h01);
    // toggle held over two edges lands back on the same pointer
    @(negedge CORE_CLK) CHOICE_TOGGLE = 1'b1;
    @(negedge CORE_CLK);
    go;
    cmp(PTR_OUT, e16);
    wr(8'ha2, 8'hff);
    rd(8'ha2);
    cmp(SFR_RDATA, 8'h09);
    wr(8'ha2, 8'h00);
    cmp(PTR_OUT, 16'h01ff);
    close_out;
  end
endmodule // test_cpu_core_regs
